// ==== core/tas_pkg.sv ====
package tas_pkg;

    // ========================================================
    // Sizes
    localparam int AXES = 2;
    localparam int DATA_W = 32;
    localparam int BUS_AW = 8;
    localparam int TBL_W = 33;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_AXSEL = 8'h04;
    localparam logic [7:0] REG_STEPS = 8'h08;
    localparam logic [7:0] REG_STEP3 = 8'h0C;
    localparam logic [7:0] REG_DTGT = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ERRCODE = 8'h18;
    localparam logic [7:0] REG_POS0 = 8'h1C;
    localparam logic [7:0] REG_POS1 = 8'h20;
    localparam logic [7:0] REG_TGT0 = 8'h24;
    localparam logic [7:0] REG_TGT1 = 8'h28;
    localparam logic [7:0] REG_TBLADDR = 8'h2C;
    localparam logic [7:0] REG_TBLDATA = 8'h30;

    // ========================================================
    // Field positions
    localparam int CMD_SIMUL_BIT = 0;
    localparam int CMD_TOPOS_BIT = 1;
    localparam int CMD_TOSPD_BIT = 2;
    localparam int CMD_DIRECT_BIT = 3;
    localparam int CMD_INDIRECT_BIT = 4;
    localparam int CMD_NUM = 5;
    localparam int CMD_DSPD_BIT = 8;
    localparam int ST_IERR_BIT = 0;
    localparam int ST_AXIS_BASE = 1;
    localparam int ST_AX_STRIDE = 3;
    localparam int ST_RUN_OFS = 0;
    localparam int ST_ERR_OFS = 1;
    localparam int ST_SPD_OFS = 2;
    localparam int TBL_AXIS_BIT = 8;
    localparam int TBL_SPD_BIT = 16;

    // ========================================================
    // Values
    localparam logic [15:0] SEL_FIRST = 16'h0000;
    localparam logic [15:0] SEL_SECOND = 16'h0001;
    localparam logic [15:0] AXIS_MASK_BOTH = 16'h0003;
    localparam logic [15:0] ERR_CODE_MASK = 16'h0128;
    localparam logic [15:0] ERR_CODE_NONE = 16'h0000;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = (PULSE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ACT_NONE, ACT_START_IND, ACT_TO_POS} tas_act_e;

endpackage

// ==== core/tas_step_mem.sv ====
`timescale 1ns/1ps

module tas_step_mem #(
    parameter int WIDTH = 33,
    parameter int AW = 7
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    // ========================================================
    // Storage with registered read
    logic [WIDTH-1:0] mem [2**AW];
    logic [WIDTH-1:0] rdata_q;

    always_ff @(posedge i_clock)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule // tas_step_mem

// ==== core/tas_sync_switch.sv ====
`timescale 1ns/1ps
// Functional notes
// - Speed-to-position command edge moves the selected axis to position control.
// - On that switch the position count clears and the target is absolute.
// - After indirect start the running step's target becomes the new target.
// - After direct start the direct-start operand target becomes the new target.
// - Position-to-speed command edge moves the selected axis to speed control.
// - On that switch the position count is kept and motion continues.
// - Axis select must be 0 or 1, else error flag and no action.
// - Simultaneous start launches both axes together from their own steps.
// - The third-axis step operand is ignored entirely.
// - A legal axis select does not change simultaneous start behaviour.
// - Each axis shows a running bit and an error bit.
// - Each axis shows a bit while under speed control.
// - Axis mask must equal 3, else error code 296 and no motion.
// - Step out of range sets axis error, not instruction error, no motion.
module tas_sync_switch
    import tas_pkg::*;
#(
    parameter int MAX_STEP = 80,
    parameter int STEP_AW = 7
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [tas_pkg::BUS_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [tas_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [tas_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_instruction_error_flag,
    output logic o_first_axis_running,
    output logic o_first_axis_error,
    output logic o_first_axis_in_speed_ctrl,
    output logic o_second_axis_running,
    output logic o_second_axis_error,
    output logic o_second_axis_in_speed_ctrl
);
    import tas_pkg::*;

    if (MAX_STEP < 1 || MAX_STEP >= 2**STEP_AW || STEP_AW > 15)
    begin : g_bad_param
        $error("MAX_STEP does not fit the step table");
    end

    localparam logic [15:0] MAX_STEP_W = 16'(MAX_STEP);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    // ========================================================
    // Bus slave and software registers
    logic wr_q, wr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] cmd_q, cmd_d, axsel_q, axsel_d, steps_q, steps_d;
    logic [31:0] step3_q, step3_d, dtgt_q, dtgt_d, tbladdr_q, tbladdr_d;
    logic wr_eff, clr_ierr;
    logic [AXES-1:0] clr_axerr, tbl_we;
    logic [15:0] errcode_q, errcode_d;
    logic ierr_q, ierr_d;
    logic [AXES-1:0] run_q, run_d, spd_q, spd_d, axerr_q, axerr_d, ind_q, ind_d;
    logic signed [31:0] pos_q [AXES];
    logic signed [31:0] pos_d [AXES];
    logic signed [31:0] tgt_q [AXES];
    logic signed [31:0] tgt_d [AXES];
    logic signed [31:0] dirt_q [AXES];
    logic signed [31:0] dirt_d [AXES];
    logic [STEP_AW-1:0] stepn_q [AXES];
    logic [STEP_AW-1:0] stepn_d [AXES];
    logic [STEP_AW-1:0] rd_addr [AXES];
    logic [TBL_W-1:0] tbl_rdata [AXES];
    tas_act_e act_q [AXES];
    tas_act_e act_d [AXES];

    function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw,
                                             logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] status_w;
    always_comb
    begin
        status_w = RESET_WORD;
        status_w[ST_IERR_BIT] = ierr_q;
        for (int a = 0; a < AXES; a++)
        begin
            status_w[ST_AXIS_BASE + a*ST_AX_STRIDE + ST_RUN_OFS] = run_q[a];
            status_w[ST_AXIS_BASE + a*ST_AX_STRIDE + ST_ERR_OFS] = axerr_q[a];
            status_w[ST_AXIS_BASE + a*ST_AX_STRIDE + ST_SPD_OFS] = spd_q[a];
        end
    end

    always_comb
    begin
        wr_d = !((i_avs_read || i_avs_write) && wr_q);
        wr_eff = i_avs_write && !wr_q;
        rdata_d = rdata_q;
        cmd_d = cmd_q;
        axsel_d = axsel_q;
        steps_d = steps_q;
        step3_d = step3_q;
        dtgt_d = dtgt_q;
        tbladdr_d = tbladdr_q;
        clr_ierr = 1'b0;
        clr_axerr = '0;
        tbl_we = '0;
        if (i_avs_read && wr_q)
        begin
            case (i_avs_address)
                REG_CMD: rdata_d = cmd_q;
                REG_AXSEL: rdata_d = axsel_q;
                REG_STEPS: rdata_d = steps_q;
                REG_STEP3: rdata_d = step3_q;
                REG_DTGT: rdata_d = dtgt_q;
                REG_STATUS: rdata_d = status_w;
                REG_ERRCODE: rdata_d = {16'h0000, errcode_q};
                REG_POS0: rdata_d = pos_q[0];
                REG_POS1: rdata_d = pos_q[1];
                REG_TGT0: rdata_d = tgt_q[0];
                REG_TGT1: rdata_d = tgt_q[1];
                REG_TBLADDR: rdata_d = tbladdr_q;
                default: rdata_d = RESET_WORD;
            endcase
        end
        if (wr_eff)
        begin
            case (i_avs_address)
                REG_CMD: cmd_d = be_merge(cmd_q, i_avs_writedata, i_avs_byteenable);
                REG_AXSEL: axsel_d = be_merge(axsel_q, i_avs_writedata, i_avs_byteenable);
                REG_STEPS: steps_d = be_merge(steps_q, i_avs_writedata, i_avs_byteenable);
                REG_STEP3: step3_d = be_merge(step3_q, i_avs_writedata, i_avs_byteenable);
                REG_DTGT: dtgt_d = be_merge(dtgt_q, i_avs_writedata, i_avs_byteenable);
                REG_TBLADDR: tbladdr_d = be_merge(tbladdr_q, i_avs_writedata,
                                                  i_avs_byteenable);
                REG_STATUS:
                begin
                    clr_ierr = i_avs_writedata[ST_IERR_BIT];
                    for (int a = 0; a < AXES; a++)
                    begin
                        clr_axerr[a] = i_avs_writedata[ST_AXIS_BASE + a*ST_AX_STRIDE + ST_ERR_OFS];
                    end
                end
                REG_TBLDATA: tbl_we[tbladdr_q[TBL_AXIS_BIT]] = 1'b1;
                default: cmd_d = cmd_q;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_q <= 1'b1;
            rdata_q <= RESET_WORD;
            cmd_q <= RESET_WORD;
            axsel_q <= RESET_WORD;
            steps_q <= RESET_WORD;
            step3_q <= RESET_WORD;
            dtgt_q <= RESET_WORD;
            tbladdr_q <= RESET_WORD;
        end
        else
        begin
            wr_q <= wr_d;
            rdata_q <= rdata_d;
            cmd_q <= cmd_d;
            axsel_q <= axsel_d;
            steps_q <= steps_d;
            step3_q <= step3_d;
            dtgt_q <= dtgt_d;
            tbladdr_q <= tbladdr_d;
        end
    end

    // ========================================================
    // Step tables, one per axis
    for (genvar g = 0; g < AXES; g++)
    begin : g_tbl
        tas_step_mem #(.WIDTH(TBL_W), .AW(STEP_AW)) u_mem (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_we(tbl_we[g]),
            .i_waddr(tbladdr_q[STEP_AW-1:0]),
            .i_wdata({tbladdr_q[TBL_SPD_BIT], i_avs_writedata}),
            .i_raddr(rd_addr[g]),
            .o_rdata(tbl_rdata[g])
        );
    end

    // ========================================================
    // Command detection and axis control
    logic [CMD_NUM-1:0] prev_q, rise;
    logic [15:0] tick_cnt_q, tick_cnt_d, axsel_op, mask_op;
    logic tick_q, tick_d, axsel_ok, axi;
    logic [15:0] step_op [AXES];
    logic [AXES-1:0] step_bad;

    assign rise = cmd_q[CMD_NUM-1:0] & ~prev_q;
    assign axsel_op = axsel_q[15:0];
    assign mask_op = step3_q[31:16];
    assign axsel_ok = (axsel_op == SEL_FIRST) || (axsel_op == SEL_SECOND);
    assign axi = axsel_op[0];
    assign step_op[0] = steps_q[15:0];
    assign step_op[1] = steps_q[31:16];
    for (genvar g = 0; g < AXES; g++)
    begin : g_chk
        assign step_bad[g] = step_op[g] > MAX_STEP_W;
    end

    always_comb
    begin
        tick_d = tick_cnt_q == TICK_LAST;
        tick_cnt_d = tick_d ? 16'h0000 : 16'(tick_cnt_q + 16'h0001);
        ierr_d = ierr_q & ~clr_ierr;
        errcode_d = errcode_q;
        run_d = run_q;
        spd_d = spd_q;
        ind_d = ind_q;
        axerr_d = axerr_q & ~clr_axerr;
        for (int a = 0; a < AXES; a++)
        begin
            pos_d[a] = pos_q[a];
            tgt_d[a] = tgt_q[a];
            dirt_d[a] = dirt_q[a];
            stepn_d[a] = stepn_q[a];
            rd_addr[a] = stepn_q[a];
            act_d[a] = ACT_NONE;
            if (tick_q && run_q[a])
            begin
                if (spd_q[a])
                    pos_d[a] = pos_q[a] + 32'sd1;
                else if (pos_q[a] == tgt_q[a])
                    run_d[a] = 1'b0;
                else if (pos_q[a] < tgt_q[a])
                    pos_d[a] = pos_q[a] + 32'sd1;
                else
                    pos_d[a] = pos_q[a] - 32'sd1;
            end
            case (act_q[a])
                ACT_START_IND:
                begin
                    run_d[a] = 1'b1;
                    spd_d[a] = tbl_rdata[a][DATA_W];
                    tgt_d[a] = pos_q[a] + $signed(tbl_rdata[a][DATA_W-1:0]);
                    ind_d[a] = 1'b1;
                end
                ACT_TO_POS:
                begin
                    pos_d[a] = 32'sd0;
                    spd_d[a] = 1'b0;
                    tgt_d[a] = $signed(tbl_rdata[a][DATA_W-1:0]);
                end
                default: ;
            endcase
        end
        if (|rise && !axsel_ok)
        begin
            ierr_d = 1'b1;
        end
        else if (rise[CMD_SIMUL_BIT])
        begin
            // Third step operand and axis select value play no part
            if (mask_op != AXIS_MASK_BOTH)
                errcode_d = ERR_CODE_MASK;
            else if (|step_bad)
                axerr_d = axerr_d | step_bad;
            else if (run_q == '0 && act_q[0] == ACT_NONE && act_q[1] == ACT_NONE)
            begin
                for (int a = 0; a < AXES; a++)
                begin
                    stepn_d[a] = step_op[a][STEP_AW-1:0];
                    rd_addr[a] = step_op[a][STEP_AW-1:0];
                    act_d[a] = ACT_START_IND;
                end
            end
        end
        else if (rise[CMD_INDIRECT_BIT])
        begin
            if (step_bad[0])
                axerr_d[axi] = 1'b1;
            else if (!run_q[axi] && act_q[axi] == ACT_NONE)
            begin
                stepn_d[axi] = step_op[0][STEP_AW-1:0];
                rd_addr[axi] = step_op[0][STEP_AW-1:0];
                act_d[axi] = ACT_START_IND;
            end
        end
        else if (rise[CMD_DIRECT_BIT] && !run_q[axi] && act_q[axi] == ACT_NONE)
        begin
            run_d[axi] = 1'b1;
            spd_d[axi] = cmd_q[CMD_DSPD_BIT];
            tgt_d[axi] = pos_q[axi] + $signed(dtgt_q);
            dirt_d[axi] = $signed(dtgt_q);
            ind_d[axi] = 1'b0;
        end
        else if (rise[CMD_TOPOS_BIT] && run_q[axi] && spd_q[axi])
        begin
            if (ind_q[axi])
            begin
                rd_addr[axi] = stepn_q[axi];
                act_d[axi] = ACT_TO_POS;
            end
            else
            begin
                pos_d[axi] = 32'sd0;
                spd_d[axi] = 1'b0;
                tgt_d[axi] = dirt_q[axi];
            end
        end
        else if (rise[CMD_TOSPD_BIT] && run_q[axi] && !spd_q[axi])
        begin
            spd_d[axi] = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            prev_q <= '0;
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            ierr_q <= 1'b0;
            errcode_q <= ERR_CODE_NONE;
            run_q <= '0;
            spd_q <= '0;
            ind_q <= '0;
            axerr_q <= '0;
            for (int a = 0; a < AXES; a++)
            begin
                pos_q[a] <= 32'sd0;
                tgt_q[a] <= 32'sd0;
                dirt_q[a] <= 32'sd0;
                stepn_q[a] <= '0;
                act_q[a] <= ACT_NONE;
            end
        end
        else
        begin
            prev_q <= cmd_q[CMD_NUM-1:0];
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            ierr_q <= ierr_d;
            errcode_q <= errcode_d;
            run_q <= run_d;
            spd_q <= spd_d;
            ind_q <= ind_d;
            axerr_q <= axerr_d;
            pos_q <= pos_d;
            tgt_q <= tgt_d;
            dirt_q <= dirt_d;
            stepn_q <= stepn_d;
            act_q <= act_d;
        end
    end

    // ========================================================
    // Outputs
    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wr_q;
    assign o_instruction_error_flag = ierr_q;
    assign o_first_axis_running = run_q[0];
    assign o_first_axis_error = axerr_q[0];
    assign o_first_axis_in_speed_ctrl = spd_q[0];
    assign o_second_axis_running = run_q[1];
    assign o_second_axis_error = axerr_q[1];
    assign o_second_axis_in_speed_ctrl = spd_q[1];

    // ========================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_simul_ok;
        rise[CMD_SIMUL_BIT] && axsel_ok && mask_op == AXIS_MASK_BOTH && step_bad == '0
            && run_q == '0 && act_q[0] == ACT_NONE && act_q[1] == ACT_NONE;
    endsequence
    sequence s_both_run;
        ##2 run_q == 2'b11;
    endsequence

    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");
    a_simul_both_start: assert property (s_simul_ok |-> s_both_run)
        else $error("simultaneous start did not run both axes");
    a_bad_axis_flag: assert property (|rise && !axsel_ok |=> ierr_q
        && act_q[0] == ACT_NONE && act_q[1] == ACT_NONE)
        else $error("illegal axis select not flagged or not suppressed");
    a_mask_code: assert property (rise[CMD_SIMUL_BIT] && axsel_ok
        && mask_op != AXIS_MASK_BOTH && run_q == '0
        |=> errcode_q == ERR_CODE_MASK ##1 run_q == '0)
        else $error("bad axis mask did not report code or moved");
    a_step_range: assert property (rise[CMD_SIMUL_BIT] && axsel_ok
        && mask_op == AXIS_MASK_BOTH && step_bad[0] && !ierr_q |=> axerr_q[0] && !ierr_q)
        else $error("step range error handled wrongly");
    a_topos_clear: assert property (act_q[1] == ACT_TO_POS |=> pos_q[1] == 32'sd0
        && !spd_q[1] && tgt_q[1] == $signed($past(tbl_rdata[1][DATA_W-1:0])))
        else $error("speed to position switch did not clear position");
    a_tospd_keep: assert property (rise == CMD_NUM'(1 << CMD_TOSPD_BIT)
        && axsel_op == SEL_FIRST && run_q[0] && !spd_q[0] && !tick_q
        |=> spd_q[0] && run_q[0] && pos_q[0] == $past(pos_q[0]))
        else $error("position to speed switch lost position or motion");
    a_edge_once: assert property (rise[CMD_SIMUL_BIT] |=> !rise[CMD_SIMUL_BIT])
        else $error("command fired twice on one rise");
endmodule // tas_sync_switch

// ==== testbench/tas_host_model.sv ====
`timescale 1ns/1ps

module tas_host_model
    import tas_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_waitrequest,
    input wire logic [tas_pkg::DATA_W-1:0] i_readdata,
    output logic [tas_pkg::BUS_AW-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [tas_pkg::DATA_W-1:0] o_writedata,
    output logic [3:0] o_byteenable
);
    // ========================================================
    // Idle bus; module position index is implicit and always zero
    initial
    begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0000_0000;
        o_byteenable = 4'hF;
    end

    // ========================================================
    // One access, held until waitrequest is seen low
    task automatic access(input logic is_wr, input logic [7:0] addr, input logic [31:0] data,
        output logic [31:0] rdata);
        @(posedge i_clock);
        o_address <= addr;
        o_read <= !is_wr;
        o_write <= is_wr;
        o_writedata <= data;
        do @(posedge i_clock); while (i_waitrequest !== 1'b0);
        rdata = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~addr;
        o_writedata <= ~data;
    endtask
endmodule // tas_host_model

// ==== testbench/tas_sync_switch_bench.sv ====
`timescale 1ns/1ps

module tas_sync_switch_bench;
    import tas_pkg::*;
    localparam int MAX_STEP = 80;
    typedef struct packed {logic [15:0] sel; logic [31:0] cmd; logic ierr;} tas_row_s;
    logic clock, nrst, read, write, waitrequest;
    logic ierr, run0, err0, spd0, run1, err1, spd1;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd, p;
    logic [3:0] byteenable;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    tas_row_s rows [7] = '{
        '{16'h0002, 32'h01, 1'b1}, '{16'h0002, 32'h02, 1'b1}, '{16'h0002, 32'h04, 1'b1},
        '{16'h0002, 32'h08, 1'b1}, '{16'hFFFF, 32'h10, 1'b1}, '{16'h0000, 32'h04, 1'b0},
        '{16'h0001, 32'h02, 1'b0}};

    // ========================================================
    // Clock, timeout, instances
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end

    tas_host_model host_u (.i_clock(clock), .i_waitrequest(waitrequest), .i_readdata(readdata),
        .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
        .o_byteenable(byteenable));

    tas_sync_switch #(.MAX_STEP(MAX_STEP), .STEP_AW(7)) dut_u (.i_clock(clock), .i_nrst(nrst),
        .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
        .i_avs_writedata(writedata), .i_avs_byteenable(byteenable), .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest), .o_instruction_error_flag(ierr),
        .o_first_axis_running(run0), .o_first_axis_error(err0), .o_first_axis_in_speed_ctrl(spd0),
        .o_second_axis_running(run1), .o_second_axis_error(err1),
        .o_second_axis_in_speed_ctrl(spd1));

    // ========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.access(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        host_u.access(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    task automatic cmd(input logic [31:0] v);
        wr(REG_CMD, v);
        wr(REG_CMD, 32'h0000_0000);
        repeat (4) @(posedge clock);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================================
    // Sequence
    initial
    begin
        nrst = 1'b0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        chk({ierr, run0, err0, spd0, run1, err1, spd1}, 32'h0);
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(REG_ERRCODE, 32'h0);
        foreach (rows[i])
        begin
            wr(REG_AXSEL, {16'h0000, rows[i].sel});
            cmd(rows[i].cmd);
            chk(ierr, rows[i].ierr);
            wr(REG_STATUS, 32'h1);
        end
        wr(REG_TBLADDR, 32'h0000_0001);
        wr(REG_TBLDATA, 32'h5);
        wr(REG_TBLADDR, 32'h0000_0102);
        wr(REG_TBLDATA, 32'h3);
        wr(REG_STEPS, 32'h0002_0001);
        wr(REG_STEP3, 32'h0003_BEEF);
        wr(REG_AXSEL, 32'h1);
        cmd(32'h1);
        chk({run0, run1, spd0, spd1}, 4'hC);
        repeat (6 * TICK_CYCLES + 40) @(posedge clock);
        chk({run0, run1}, 2'b00);
        rd_chk(REG_POS0, 32'h5);
        rd_chk(REG_POS1, 32'h3);
        wr(REG_STEPS, {16'h0002, 16'(MAX_STEP + 1)});
        wr(REG_CMD, 32'h1);
        repeat (4) @(posedge clock);
        chk({ierr, err0, err1, run0, run1}, 5'b01000);
        wr(REG_STATUS, 32'h24);
        wr(REG_CMD, 32'h1);
        repeat (4) @(posedge clock);
        chk({err0, run0, run1}, 3'b000);
        wr(REG_CMD, 32'h0);
        wr(REG_STEPS, 32'h0002_0001);
        wr(REG_STEP3, 32'h0000_0001);
        cmd(32'h1);
        rd_chk(REG_ERRCODE, {16'h0000, ERR_CODE_MASK});
        chk({run0, run1}, 2'b00);
        wr(REG_STEP3, 32'h0003_0000);
        wr(REG_AXSEL, 32'h0);
        wr(REG_DTGT, 32'h4);
        cmd(32'h108);
        chk({run0, spd0}, 2'b11);
        repeat (2 * TICK_CYCLES) @(posedge clock);
        chk(spd0, 1'b1);
        cmd(32'h1 << CMD_TOPOS_BIT);
        chk({run0, spd0}, 2'b10);
        rd_chk(REG_TGT0, 32'h4);
        repeat (5 * TICK_CYCLES + 40) @(posedge clock);
        chk(run0, 1'b0);
        rd_chk(REG_POS0, 32'h4);
        wr(REG_DTGT, 32'd100);
        cmd(32'h8);
        repeat (2 * TICK_CYCLES) @(posedge clock);
        host_u.access(1'b0, REG_POS0, 32'h0, p);
        cmd(32'h1 << CMD_TOSPD_BIT);
        chk({run0, spd0}, 2'b11);
        host_u.access(1'b0, REG_POS0, 32'h0, rd);
        chk(rd >= p && p > 32'h4, 1'b1);
        wr(REG_TBLADDR, 32'h0001_0103);
        wr(REG_TBLDATA, 32'h2);
        wr(REG_STEPS, 32'h0000_0003);
        wr(REG_AXSEL, 32'h1);
        cmd(32'h1 << CMD_INDIRECT_BIT);
        chk({run1, spd1}, 2'b11);
        cmd(32'h1 << CMD_TOPOS_BIT);
        rd_chk(REG_TGT1, 32'h2);
        repeat (3 * TICK_CYCLES + 40) @(posedge clock);
        chk(run1, 1'b0);
        rd_chk(REG_POS1, 32'h2);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({ierr, run0, err0, spd0, run1, err1, spd1, waitrequest}, 8'h01);
        nrst <= 1'b1;
        rd_chk(REG_POS0, 32'h0);
        rd_chk(REG_ERRCODE, 32'h0);
        summarize();
    end
endmodule // tas_sync_switch_bench
